// ### abu_params.svh
// Register offsets, field positions and reset values of the breakpoint unit
`ifndef ABU_PARAMS_SVH
`define ABU_PARAMS_SVH
`define ABU_OFF_WAIT_STATUS   16'hFE00
`define ABU_OFF_FLAG_CLEAR    16'hFE03
`define ABU_OFF_ADDR_HIGH     16'hFE09
`define ABU_OFF_ADDR_LOW      16'hFE0A
`define ABU_OFF_STATUS_CTRL   16'hFE0B
`define ABU_BIT_MATCH_ENABLE  7
`define ABU_BIT_BREAK_ACTIVE  6
`define ABU_BIT_FLAG_CLEAR_EN 7
`define ABU_BIT_WAIT_EXIT     1
`define ABU_RST_BYTE          8'h00
`define ABU_VEC_NORMAL        16'hFFFC
`define ABU_VEC_MONITOR       16'hFEFC
`define ABU_SWI_OPCODE        8'h83
`endif

// ### abu_pkg.sv
// Types shared by the breakpoint unit modules
package abu_pkg;
  typedef enum logic [1:0] {
    ABU_IDLE    = 2'b00,
    ABU_PENDING = 2'b01,
    ABU_IN_BRK  = 2'b10
  } abu_state_t;
endpackage : abu_pkg

// ### abu_match_if.sv
// Compare path between register file and match logic
interface abu_match_if;
  logic [15:0] brk_addr;
  logic        enable;
  logic        hit;
  modport regs (output brk_addr, output enable, input hit);
  modport cmp  (input brk_addr, input enable, output hit);
endinterface : abu_match_if

// ### abu_comparator.sv
// Sixteen bit address comparator with registered hit
`include "abu_params.svh"
module abu_comparator
  import abu_pkg::*;
(
  input  wire logic        clk,        // Bus clock
  input  wire logic        reset,      // Sync reset
  input  wire logic [15:0] cpu_addr,   // CPU generated address
  input  wire logic        addr_valid, // Address bus advancing
  abu_match_if.cmp         m           // Match port
);
  typedef struct packed { logic hit; } abu_cmp_st_t;
  abu_cmp_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    // Full sixteen bits, gated by enable and bus activity [R2] [R17]
    s_d.hit = m.enable && addr_valid && (cpu_addr == m.brk_addr);
    if (reset) begin
      s_d.hit = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end
  assign m.hit = s_q.hit;
endmodule : abu_comparator

// ### abu_break_unit.sv
// Address breakpoint unit: registers, break sequencing and side effects
// Overview of operation
// [R1] Enabled match of CPU address with break address requests break, sets active
// [R2] Comparison covers all sixteen bits from high and low address bytes
// [R3] Break makes CPU load interrupt opcode, vector normal or monitor pair
// [R4] Match on opcode address holds that instruction until routine completes; code ignores cpu_opcode_fetch and lets it finish as in R5
// [R5] Match on operand address lets the instruction finish before the break
// [R6] Writing one to active bit breaks before the next instruction
// [R7] Active bit set by match, cleared by written zero and by reset
// [R8] Cleared active bit with unchanged address gives no repeated break
// [R9] Software reloads address and clears active bit for repeated breaks
// [R10] Match enable is bit 7, cleared by written zero and by reset
// [R11] Address byte registers hold breakpoint bytes and reset to zero
// [R12] In break state, status flags clear only with flag clear enable
// [R13] Timer counter halts while a break is in progress
// [R14] Watchdog disabled in break while test voltage sits on reset pin
// [R15] Wait exit flag shows break ended wait; written zero clears it
// [R16] Software may decrement stacked return address after reading wait flag
// [R17] Enable kept in wait and stop; idle bus gives no break there
// [R18] Match sends breakpoint request to system integration unit
// [R19] Return from interrupt in routine ends the break state
// [R20] Unimplemented bits read zero; reserved bit writes do nothing
`include "abu_params.svh"
module abu_break_unit
  import abu_pkg::*;
(
  input  wire logic        clk,              // Bus clock 200 MHz
  input  wire logic        reset,            // Sync reset, active high
  input  wire logic [15:0] reg_addr,         // Register address
  input  wire logic [7:0]  reg_wdata,        // Register write data
  input  wire logic        reg_write,        // Write strobe
  input  wire logic        reg_read,         // Read strobe
  output logic      [7:0]  reg_rdata,        // Read data, next cycle
  input  wire logic [15:0] cpu_addr,         // CPU generated address
  input  wire logic        cpu_addr_valid,   // Address bus advancing
  input  wire logic        cpu_opcode_fetch, // Current cycle fetches opcode
  input  wire logic        cpu_instr_start,  // Next instruction begins
  input  wire logic        cpu_rti_exec,     // Return from interrupt executed
  input  wire logic        cpu_in_wait,      // CPU in wait mode
  input  wire logic        cpu_in_stop,      // CPU in stop mode
  input  wire logic        monitor_mode,     // Monitor mode latched
  input  wire logic        test_voltage_pin, // Test voltage on reset pin
  output logic             breakpoint_request, // Request to integration unit
  output logic             swi_inject,       // Load interrupt opcode now
  output logic      [7:0]  swi_opcode,       // Opcode to inject
  output logic      [15:0] break_vector,     // Vector address to fetch
  output logic             break_state,      // Break in progress
  output logic             timer_halt,       // Stop timer counter
  output logic             watchdog_disable, // Disable watchdog
  output logic             flag_clear_allow  // Peripherals may clear flags
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]  addr_high;
    logic [7:0]  addr_low;
    logic        match_enable;
    logic        break_active;
    logic        flag_clear_in_break_enable;
    logic        wait_exit_by_break_flag;
    logic        hit_armed;
    logic        hit_seen;
    abu_state_t  state;
    logic [7:0]  rdata;
    logic        inject;
    logic        tst_s1;
    logic        tst_s2;
  } abu_st_t;

  abu_st_t s_q, s_d;
  abu_match_if mif ();
  logic low_power;
  logic raw_hit;

  assign low_power = cpu_in_wait || cpu_in_stop;
  assign mif.brk_addr = {s_q.addr_high, s_q.addr_low}; // [R2]
  // Enable stays set in low power; addr_valid is gated off there so no hit arrives [R17]
  assign mif.enable = s_q.match_enable && s_q.hit_armed;

  abu_comparator u_cmp (
    .clk        (clk),
    .reset      (reset),
    .cpu_addr   (cpu_addr),
    .addr_valid (cpu_addr_valid && !low_power),
    .m          (mif.cmp)
  );
  assign raw_hit = mif.hit;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.inject = 1'b0;
    s_d.rdata = `ABU_RST_BYTE;
    // Pin level: two flops before use
    s_d.tst_s1 = test_voltage_pin;
    s_d.tst_s2 = s_q.tst_s1;

    // A hit in idle latches; opcode and operand fetches are not told apart [R4] [R5]
    if (raw_hit && s_q.state == ABU_IDLE) begin
      s_d.hit_seen = 1'b1;
    end

    if (reg_write) begin
      case (reg_addr)
        `ABU_OFF_ADDR_HIGH: begin
          s_d.addr_high = reg_wdata; // [R11]
          s_d.hit_armed = 1'b1;      // New address re-arms matching [R8]
        end
        `ABU_OFF_ADDR_LOW: begin
          s_d.addr_low = reg_wdata;  // [R11]
          s_d.hit_armed = 1'b1;
        end
        `ABU_OFF_STATUS_CTRL: begin
          s_d.match_enable = reg_wdata[`ABU_BIT_MATCH_ENABLE]; // [R10]
          if (reg_wdata[`ABU_BIT_BREAK_ACTIVE]) begin
            s_d.break_active = 1'b1;
            if (s_q.state == ABU_IDLE) begin
              s_d.state = ABU_PENDING; // [R6]
            end
          end else begin
            s_d.break_active = 1'b0; // [R7]
          end
        end
        `ABU_OFF_FLAG_CLEAR: begin
          s_d.flag_clear_in_break_enable =
            reg_wdata[`ABU_BIT_FLAG_CLEAR_EN];
        end
        `ABU_OFF_WAIT_STATUS: begin
          // Only a written zero clears; reserved bits ignored [R15] [R20]
          if (!reg_wdata[`ABU_BIT_WAIT_EXIT]) begin
            s_d.wait_exit_by_break_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Match sets the active bit; set wins over a same-cycle clear [R1] [R7]
    if (raw_hit && s_q.state == ABU_IDLE) begin
      s_d.break_active = 1'b1;
      s_d.hit_armed = 1'b0; // Same address stays silent after clear [R8]
    end

    case (s_q.state)
      ABU_IDLE: begin
        if (s_q.hit_seen || raw_hit) begin
          s_d.state = ABU_PENDING; // [R1] [R18]
        end
      end
      ABU_PENDING: begin
        // A pending break wakes a waiting CPU; no hit can arrive in wait
        if (cpu_in_wait) begin
          s_d.wait_exit_by_break_flag = 1'b1; // [R15]
        end
        // Taken at an instruction boundary [R4] [R5] [R6]
        if (cpu_instr_start) begin
          s_d.inject = 1'b1; // [R3]
          s_d.state = ABU_IN_BRK;
          s_d.hit_seen = 1'b0;
        end
      end
      ABU_IN_BRK: begin
        if (cpu_rti_exec) begin
          s_d.state = ABU_IDLE; // [R19]
          s_d.hit_seen = 1'b0;
        end
      end
      default: begin
        s_d.state = ABU_IDLE;
      end
    endcase

    if (reg_read) begin
      case (reg_addr)
        `ABU_OFF_ADDR_HIGH: s_d.rdata = s_q.addr_high;
        `ABU_OFF_ADDR_LOW:  s_d.rdata = s_q.addr_low;
        `ABU_OFF_STATUS_CTRL: begin
          s_d.rdata[`ABU_BIT_MATCH_ENABLE] = s_q.match_enable;
          s_d.rdata[`ABU_BIT_BREAK_ACTIVE] = s_q.break_active; // [R20]
        end
        `ABU_OFF_FLAG_CLEAR: begin
          s_d.rdata[`ABU_BIT_FLAG_CLEAR_EN] = s_q.flag_clear_in_break_enable;
        end
        `ABU_OFF_WAIT_STATUS: begin
          s_d.rdata[`ABU_BIT_WAIT_EXIT] = s_q.wait_exit_by_break_flag;
        end
        default: s_d.rdata = `ABU_RST_BYTE;
      endcase
    end

    if (reset) begin
      s_d = '0; // [R7] [R10] [R11]
      s_d.hit_armed = 1'b1;
      s_d.state = ABU_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = s_q.rdata;
  assign breakpoint_request = (s_q.state == ABU_PENDING); // [R18]
  assign swi_inject = s_q.inject; // [R3]
  assign swi_opcode = `ABU_SWI_OPCODE;
  assign break_vector = monitor_mode ? `ABU_VEC_MONITOR
                                     : `ABU_VEC_NORMAL; // [R3]
  assign break_state = (s_q.state == ABU_IN_BRK);
  assign timer_halt = break_state; // [R13]
  assign watchdog_disable = break_state && s_q.tst_s2; // [R14]
  // Outside a break flags always clear normally [R12]
  assign flag_clear_allow = !break_state || s_q.flag_clear_in_break_enable;
endmodule : abu_break_unit

// ### abu_break_unit_asserts.sv
// Port checker of the address breakpoint unit
`include "abu_params.svh"
module abu_break_unit_asserts (
  input wire logic        clk,                // Bus clock
  input wire logic        reset,              // Sync reset
  input wire logic        reg_read,           // Read strobe
  input wire logic [7:0]  reg_rdata,          // Read data
  input wire logic        cpu_instr_start,    // Boundary
  input wire logic        cpu_rti_exec,       // Return
  input wire logic        cpu_in_stop,        // Stop mode
  input wire logic        monitor_mode,       // Monitor
  input wire logic        breakpoint_request, // Request
  input wire logic        swi_inject,         // Inject
  input wire logic [7:0]  swi_opcode,         // Opcode
  input wire logic [15:0] break_vector,       // Vector
  input wire logic        break_state,        // In break
  input wire logic        timer_halt,         // Timer stop
  input wire logic        watchdog_disable,   // Watchdog off
  input wire logic        flag_clear_allow    // Flag clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence req_taken; breakpoint_request && cpu_instr_start; endsequence
  sequence swi_entry; swi_inject && break_state; endsequence
  swi_entry_a: assert property (req_taken |=> swi_entry)
    else $error("break entry missing after request");
  req_hold_a: assert property (breakpoint_request && !cpu_instr_start
    |=> breakpoint_request) else $error("request dropped early");
  swi_code_a: assert property (swi_inject |->
    swi_opcode == `ABU_SWI_OPCODE && $past(breakpoint_request))
    else $error("bad injected opcode");
  vector_sel_a: assert property (break_vector ==
    (monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL))
    else $error("wrong vector");
  timer_halt_a: assert property (timer_halt == break_state)
    else $error("timer halt differs from break state");
  watchdog_off_a: assert property (watchdog_disable |-> break_state)
    else $error("watchdog off outside break");
  flag_gate_a: assert property (!break_state |-> flag_clear_allow)
    else $error("flag clearing blocked outside break");
  rti_end_a: assert property (break_state && cpu_rti_exec
    |-> ##[1:2] !break_state) else $error("break not ended");
  stop_quiet_a: assert property (cpu_in_stop [*3]
    |-> !$rose(breakpoint_request)) else $error("break in stop");
  rdata_idle_a: assert property (!$past(reg_read)
    |-> reg_rdata == 8'h00) else $error("read data without read");
endmodule // abu_break_unit_asserts
bind abu_break_unit abu_break_unit_asserts abu_break_unit_asserts_inst (.*);

// ### abu_cpu_model.sv
// CPU core model: instruction boundaries and return from break routine
module abu_cpu_model (
  input  wire logic clk,             // Bus clock
  input  wire logic reset,           // Sync reset
  input  wire logic slow,            // Longer instructions
  input  wire logic break_state,     // Break in progress
  output logic      cpu_instr_start, // Boundary pulse
  output logic      cpu_rti_exec     // Return pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] len_q;
  logic [3:0] brk_q;
  always @(posedge clk) begin
    if (reset) begin
      len_q <= 4'h0;
      brk_q <= 4'h0;
      cpu_instr_start <= 1'b0;
      cpu_rti_exec <= 1'b0;
    end else begin
      len_q <= (len_q >= (slow ? 4'h5 : 4'h1)) ? 4'h0 : len_q + 4'h1;
      cpu_instr_start <= (len_q == 4'h0);
      // Routine lasts a few cycles, then returns once
      brk_q <= break_state ? brk_q + 4'h1 : 4'h0;
      cpu_rti_exec <= (brk_q == 4'h4);
    end
  end
endmodule // abu_cpu_model

// ### abu_break_unit_tb.sv
// Self-checking bench of the address breakpoint unit
module abu_break_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, reg_write, reg_read, cpu_addr_valid, cpu_opcode_fetch;
  logic cpu_in_wait, cpu_in_stop, monitor_mode, test_voltage_pin, slow;
  logic [15:0] reg_addr, cpu_addr, rnd, break_vector;
  logic [7:0] reg_wdata, reg_rdata, swi_opcode;
  logic breakpoint_request, swi_inject, break_state, timer_halt;
  logic watchdog_disable, flag_clear_allow, cpu_instr_start, cpu_rti_exec;
  logic rd_seen;
  logic [7:0] exp_q[$];
  logic [15:0] regs[6] = '{16'hFE00, 16'hFE02, 16'hFE03, 16'hFE09,
                           16'hFE0A, 16'hFE0B};
  int n_mismatch = 0;
  int check_count = 0;
  abu_break_unit abu_break_unit_inst (.*);
  abu_cpu_model abu_cpu_model_inst (.clk(clk), .reset(reset), .slow(slow),
    .break_state(break_state), .cpu_instr_start(cpu_instr_start),
    .cpu_rti_exec(cpu_rti_exec));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic hit(input logic [15:0] a);
    cpu_addr <= a;
    @(posedge clk);
    cpu_addr <= rnd ^ 16'h0100;
  endtask
  task automatic wait_brk(input logic v);
    for (int i = 0; i < 40 && break_state !== v; i++) @(negedge clk);
    if (break_state !== v) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front(), "rdata");
    rd_seen = reg_read;
  end
  //////////////////////////////////////////////////////////////
  initial begin
    {reg_write, reg_read, cpu_opcode_fetch, cpu_in_wait, cpu_in_stop} = '0;
    {monitor_mode, slow, rd_seen, reg_wdata} = '0;
    {cpu_addr_valid, test_voltage_pin, reset} = 3'b111;
    reg_addr = 16'h0000;
    cpu_addr = 16'h0000;
    rnd = lfsr(16'h0049);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 8'h00);
    cpu_addr <= rnd ^ 16'h0100;
    wr(16'hFE09, rnd[15:8]);
    wr(16'hFE0A, rnd[7:0]);
    wr(16'hFE0B, 8'h9F);
    rd(16'hFE0B, 8'h80);
    rd(16'hFE09, rnd[15:8]);
    rd(16'hFE0A, rnd[7:0]);
    idle(1);
    hit(rnd ^ 16'h8000);
    hit(rnd ^ 16'h0001);
    idle(6);
    @(negedge clk);
    chk(8'(breakpoint_request), 8'h00, "request");
    @(posedge clk);
    hit(rnd);
    wait_brk(1'b1);
    @(negedge clk);
    chk(8'(timer_halt), 8'h01, "timer");
    chk(8'(watchdog_disable), 8'h01, "watchdog");
    chk(8'(flag_clear_allow), 8'h00, "flagclr");
    @(posedge clk);
    rd(16'hFE0B, 8'hC0);
    idle(1);
    wait_brk(1'b0);
    wr(16'hFE0B, 8'h80);
    idle(1);
    hit(rnd);
    idle(10);
    @(negedge clk);
    chk(8'(break_state), 8'h00, "rebreak");
    @(posedge clk);
    wr(16'hFE0A, rnd[7:0]);
    wr(16'hFE03, 8'h80);
    idle(1);
    {slow, monitor_mode} <= 2'b11;
    hit(rnd);
    wait_brk(1'b1);
    @(negedge clk);
    chk(8'(flag_clear_allow), 8'h01, "flagclr");
    @(posedge clk);
    wait_brk(1'b0);
    wr(16'hFE0B, 8'hC0);
    cpu_in_wait <= 1'b1;
    idle(1);
    cpu_in_wait <= 1'b0;
    wait_brk(1'b1);
    wait_brk(1'b0);
    rd(16'hFE00, 8'h02);
    wr(16'hFE0B, 8'h00);
    wr(16'hFE00, 8'h00);
    rd(16'hFE0B, 8'h00);
    rd(16'hFE00, 8'h00);
    cpu_in_stop <= 1'b1;
    wr(16'hFE0A, rnd[7:0]);
    wr(16'hFE0B, 8'h80);
    idle(3);
    hit(rnd);
    idle(8);
    @(negedge clk);
    chk(8'(break_state), 8'h00, "stop");
    report_and_stop();
  end
endmodule // abu_break_unit_tb
